// ---- core/byte_fifo2.sv ----
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo2
  import eeprom_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  byte_stream_if.snk      wr,
  byte_stream_if.src      rd
);

  logic [7:0] slot_r [FIFO_DEPTH];
  logic       wr_idx_r;
  logic       rd_idx_r;
  logic [1:0] count_r;
  logic       push;
  logic       pop;

  assign wr.ready = (count_r != 2'(FIFO_DEPTH));
  assign rd.valid = (count_r != 2'h0);
  assign rd.data  = slot_r[rd_idx_r];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      slot_r[wr_idx_r] <= wr.data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      count_r  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_idx_r <= ~wr_idx_r;
      end
      if (pop)
      begin
        rd_idx_r <= ~rd_idx_r;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 2'h1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- core/byte_stream_if.sv ----
// Valid/ready byte stream between the bus receiver and the page buffer.
`timescale 1ns/1ns
`default_nettype none
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- core/eeprom_pkg.sv ----
// Shared constants and types for the serial EEPROM slave.
package eeprom_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          MEM_DEPTH       = 256;
  localparam int          PAGE_SIZE       = 8;
  localparam int          PAGE_LSB_W      = 3;
  localparam logic [3:0]  DEVICE_CODE     = 4'hA;
  localparam int          CODE_MSB        = 7;
  localparam int          CODE_LSB        = 4;
  localparam int          RW_BIT          = 0;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam int          FIFO_DEPTH      = 2;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          T_WRITE_MS      = 5;
  localparam int          WRITE_CYCLE_CLKS = (T_WRITE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          BUSY_CNT_W      = 20;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT
  } link_state_type;

endpackage

// ---- core/eeprom_slave.sv ----
// Two-wire serial EEPROM slave: bus decoding, pointer, page buffer and write cycle.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Write starts with control byte: code, three ignored bits, low direction bit.
// - Control byte is acknowledged only when its upper four bits equal 1010.
// - Word address byte after write control loads the pointer and is acknowledged.
// - Byte write: data byte acknowledged, following Stop starts the write cycle.
// - No acknowledge of any byte while the internal write cycle runs.
// - Up to eight data bytes wait in the page buffer until Stop.
// - Each data byte bumps only the low three pointer bits; extra bytes overwrite.
// - Page writes wrap to the start of the same eight-byte page.
// - The self-timed write cycle ends within 5 ms.
// - Polling is refused while busy and acknowledged once the cycle ends.
// - Write-protect high blocks every array write; reads stay unaffected.
// - A control byte with direction bit one selects a read, checked likewise.
// - Current address read returns the byte one past the last access.
// - Master leaves last read byte unacknowledged; device then releases the line.
// - Random read: address set by a write header, pointer kept without writing.
// - Each master acknowledge in a read fetches the next sequential byte.
// - The pointer steps by one after every byte read.
// - Data changes only while clock low; changes with clock high are Start/Stop.
// - Chip-select pins and block bits of the control byte are ignored.
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CLKS
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic sda_out_r,
  output var  logic sda_oe_n_r,
  input  wire logic write_protect,
  input  wire logic unused_chip_select_0,
  input  wire logic unused_chip_select_1,
  input  wire logic unused_chip_select_2,
  output var  logic write_busy_r
);

  logic                  scl_m_r, scl_s_r, scl_d_r;
  logic                  sda_m_r, sda_s_r, sda_d_r;
  logic                  wp_m_r, wp_s_r;
  logic                  start_ev, stop_ev, scl_rise, scl_fall;
  link_state_type        st_r, after_r;
  logic [3:0]            bit_cnt_r;
  logic                  ack_r, mack_ok_r;
  logic [7:0]            rx_sh_r, tx_sh_r;
  logic [ADDR_W-1:0]     ptr_r;
  logic [DATA_W-1:0]     mem_r [MEM_DEPTH];
  logic [DATA_W-1:0]     page_r [PAGE_SIZE];
  logic [PAGE_SIZE-1:0]  page_vld_r;
  logic [BUSY_CNT_W-1:0] busy_cnt_r;
  logic [DATA_W-1:0]     rd_byte;
  logic                  byte_end, byte_take, addr_load, rd_load, commit_go, drain;

  byte_stream_if rx_bytes ();
  byte_stream_if page_bytes ();

  byte_fifo2 u_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (rx_bytes.snk),
    .rd  (page_bytes.src)
  );

  // Pins come from the master's domain, so each passes two flops first.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      wp_m_r  <= 1'b0;
      wp_s_r  <= 1'b0;
    end
    else
    begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      wp_m_r  <= write_protect;
      wp_s_r  <= wp_m_r;
    end
  end

  assign start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_ev  = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;

  assign rd_byte  = mem_r[ptr_r];
  assign byte_end = scl_fall && !ack_r && (bit_cnt_r == BITS_PER_BYTE);

  always_comb
  begin
    byte_take = 1'b0;
    unique case (st_r)
      ST_CTRL:  byte_take = (rx_sh_r[CODE_MSB:CODE_LSB] == DEVICE_CODE) && !write_busy_r;
      ST_ADDR:  byte_take = 1'b1;
      ST_WDATA: byte_take = rx_bytes.ready;
      ST_IDLE, ST_RDATA, ST_WAIT: byte_take = 1'b0;
    endcase
  end

  assign addr_load = byte_end && (st_r == ST_ADDR);
  assign rd_load   = scl_fall && ack_r && ((st_r == ST_RDATA) ? mack_ok_r :
                     (st_r == ST_CTRL && after_r == ST_RDATA));
  assign rx_bytes.valid = byte_end && (st_r == ST_WDATA) && rx_bytes.ready;
  assign rx_bytes.data  = rx_sh_r;
  // A full buffer stalls the bus side by refusing the acknowledge.
  assign page_bytes.ready = !write_busy_r;
  assign drain     = page_bytes.valid && page_bytes.ready;
  assign commit_go = stop_ev && (page_vld_r != '0) && !wp_s_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r       <= ST_IDLE;
      after_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      ack_r      <= 1'b0;
      mack_ok_r  <= 1'b0;
      rx_sh_r    <= 8'h00;
      tx_sh_r    <= 8'h00;
      sda_oe_n_r <= 1'b1;
    end
    else if (start_ev)
    begin
      st_r       <= ST_CTRL;
      bit_cnt_r  <= 4'h0;
      ack_r      <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end
    else if (stop_ev)
    begin
      st_r       <= ST_IDLE;
      ack_r      <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end
    else if (scl_rise)
    begin
      if (st_r == ST_RDATA)
      begin
        if (ack_r)
        begin
          mack_ok_r <= !sda_s_r;
        end
        else
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
      else if ((st_r == ST_CTRL || st_r == ST_ADDR || st_r == ST_WDATA) && !ack_r
               && bit_cnt_r != BITS_PER_BYTE)
      begin
        rx_sh_r   <= {rx_sh_r[6:0], sda_s_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (st_r)
        ST_CTRL, ST_ADDR, ST_WDATA:
        begin
          if (ack_r)
          begin
            ack_r      <= 1'b0;
            bit_cnt_r  <= 4'h0;
            st_r       <= after_r;
            sda_oe_n_r <= rd_load ? rd_byte[7] : 1'b1;
            tx_sh_r    <= {rd_byte[6:0], 1'b0};
          end
          else if (byte_end)
          begin
            if (byte_take)
            begin
              ack_r      <= 1'b1;
              sda_oe_n_r <= 1'b0;
              if (st_r == ST_CTRL)
              begin
                after_r <= rx_sh_r[RW_BIT] ? ST_RDATA : ST_ADDR;
              end
              else
              begin
                after_r <= ST_WDATA;
              end
            end
            else
            begin
              st_r <= ST_WAIT;
            end
          end
        end
        ST_RDATA:
        begin
          if (ack_r)
          begin
            ack_r <= 1'b0;
            if (mack_ok_r)
            begin
              bit_cnt_r  <= 4'h0;
              sda_oe_n_r <= rd_byte[7];
              tx_sh_r    <= {rd_byte[6:0], 1'b0};
            end
            else
            begin
              st_r <= ST_WAIT;
            end
          end
          else if (bit_cnt_r == BITS_PER_BYTE)
          begin
            sda_oe_n_r <= 1'b1;
            ack_r      <= 1'b1;
          end
          else
          begin
            sda_oe_n_r <= tx_sh_r[7];
            tx_sh_r    <= {tx_sh_r[6:0], 1'b0};
          end
        end
        ST_IDLE, ST_WAIT:
        begin
          sda_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // Open-drain: the pin value is always low and only the enable moves.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_out_r <= 1'b0;
    end
    else
    begin
      sda_out_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_r <= 8'h00;
    end
    else if (addr_load)
    begin
      ptr_r <= rx_sh_r;
    end
    else if (drain)
    begin
      ptr_r <= {ptr_r[ADDR_W-1:PAGE_LSB_W], ptr_r[PAGE_LSB_W-1:0] + 3'h1};
    end
    else if (rd_load)
    begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_vld_r <= '0;
    end
    else if (addr_load || stop_ev)
    begin
      page_vld_r <= '0;
    end
    else if (drain)
    begin
      page_vld_r[ptr_r[PAGE_LSB_W-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (drain)
    begin
      page_r[ptr_r[PAGE_LSB_W-1:0]] <= page_bytes.data;
    end
  end

  // The array is written in one clock; the busy time models the cell programming.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < PAGE_SIZE; i++)
    begin
      if (commit_go && page_vld_r[i])
      begin
        mem_r[{ptr_r[ADDR_W-1:PAGE_LSB_W], 3'(i)}] <= page_r[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      write_busy_r <= 1'b0;
      busy_cnt_r   <= '0;
    end
    else if (commit_go)
    begin
      write_busy_r <= 1'b1;
      busy_cnt_r   <= BUSY_CNT_W'(WRITE_CYCLES - 1);
    end
    else if (write_busy_r)
    begin
      if (busy_cnt_r == '0)
      begin
        write_busy_r <= 1'b0;
      end
      else
      begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
    end
  end

  sequence s_ctrl_end;
    st_r == ST_CTRL && byte_end;
  endsequence

  sequence s_stop_seen;
    stop_ev;
  endsequence

  a_busy_no_ack: assert property (@(posedge clk) disable iff (rst)
    write_busy_r |-> sda_oe_n_r) else $error("acknowledge driven while busy");
  a_ctrl_code_match: assert property (@(posedge clk) disable iff (rst)
    s_ctrl_end ##0 (rx_sh_r[CODE_MSB:CODE_LSB] != DEVICE_CODE) |=> sda_oe_n_r && st_r == ST_WAIT)
    else $error("foreign control code acknowledged");
  a_addr_ptr_load: assert property (@(posedge clk) disable iff (rst)
    addr_load |=> ptr_r == $past(rx_sh_r)) else $error("word address not loaded");
  a_page_low_wrap: assert property (@(posedge clk) disable iff (rst)
    drain |=> ptr_r[ADDR_W-1:PAGE_LSB_W] == $past(ptr_r[ADDR_W-1:PAGE_LSB_W])
              && ptr_r[PAGE_LSB_W-1:0] == $past(ptr_r[PAGE_LSB_W-1:0]) + 3'h1)
    else $error("page pointer left its page");
  a_wp_no_commit: assert property (@(posedge clk) disable iff (rst)
    wp_s_r |-> !commit_go) else $error("write while protected");
  a_busy_after_stop: assert property (@(posedge clk) disable iff (rst)
    $rose(write_busy_r) |-> $past(stop_ev)) else $error("commit without Stop");
  a_write_time_bound: assert property (@(posedge clk) disable iff (rst)
    busy_cnt_r <= BUSY_CNT_W'(WRITE_CYCLES - 1)) else $error("write cycle too long");
  a_busy_ends: assert property (@(posedge clk) disable iff (rst)
    write_busy_r && busy_cnt_r == '0 && !commit_go |=> !write_busy_r)
    else $error("busy did not end");
  a_stop_release: assert property (@(posedge clk) disable iff (rst)
    s_stop_seen |=> sda_oe_n_r && st_r == ST_IDLE) else $error("line held after Stop");
  a_start_decode: assert property (@(posedge clk) disable iff (rst)
    start_ev |=> st_r == ST_CTRL && bit_cnt_r == 4'h0) else $error("Start not decoded");
  a_read_step: assert property (@(posedge clk) disable iff (rst)
    rd_load && !addr_load && !drain |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not step");

endmodule
`default_nettype wire

// ---- dv/i2c_master_model.sv ----
// Behavioural two-wire bus master that drives the EEPROM slave.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model
(
  output var  logic scl,
  output var  logic pull,
  input  wire logic sda
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // Data moves only with clock low.
  task automatic bit_cyc(input logic b, output logic s);
    pull = ~b;
    #31 scl = 1'b1;
    #31 s = sda;
    #32 scl = 1'b0;
    #31;
  endtask

  // Start is a fall with clock high.
  task automatic start();
    pull = 1'b0;
    #31 scl = 1'b1;
    #63 pull = 1'b1;
    #63 scl = 1'b0;
    #31;
  endtask

  // Stop is a rise with clock high.
  task automatic stop();
    pull = 1'b1;
    #31 scl = 1'b1;
    #63 pull = 1'b0;
    #63;
  endtask

  // Eight bits MSB first, then the ack slot.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(d[i], s);
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask

  // An ack asks for more; no ack ends the read.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b1, s);
      d[i] = s;
    end
    bit_cyc(last, s);
  endtask
endmodule
`default_nettype wire

// ---- dv/serial_eeprom_slave_access_test.sv ----
// Self-checking bench for the serial EEPROM slave.
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_slave_access_test
  import eeprom_pkg::*;
;
  // A short write cycle keeps polling loops within a few bus bytes.
  localparam int WR_CYC = 200;
  logic        clk;
  logic        rst;
  logic        wp;
  logic [2:0]  cs;
  logic        scl;
  logic        pull;
  wire logic   sda;
  logic        out_bit;
  logic        oe_n;
  logic        busy;
  logic [31:0] busy_cnt;
  int          n_mismatch;
  int          compares;

  // The line has a pull-up; either party may pull it low.
  assign sda = ~pull & (oe_n | out_bit);

  always #5 clk = ~clk;

  always @(posedge clk)
    if (busy)
      busy_cnt <= busy_cnt + 32'h1;

  i2c_master_model i2c_master_model_i (
    .scl  (scl),
    .pull (pull),
    .sda  (sda)
  );

  eeprom_slave #(.WRITE_CYCLES(WR_CYC)) eeprom_slave_i (
    .clk                  (clk),
    .rst                  (rst),
    .scl_in               (scl),
    .sda_in               (sda),
    .sda_out_r            (out_bit),
    .sda_oe_n_r           (oe_n),
    .write_protect        (wp),
    .unused_chip_select_0 (cs[0]),
    .unused_chip_select_1 (cs[1]),
    .unused_chip_select_2 (cs[2]),
    .write_busy_r         (busy)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic set_in(input logic wp_v, input logic [2:0] cs_v);
    @(posedge clk);
    #1 wp = wp_v;
    cs = cs_v;
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    i2c_master_model_i.wr_byte(d, a);
    check("ack", {31'h0, exp_ack}, {31'h0, a});
  endtask

  task automatic write_page(input logic [7:0] a, input logic [7:0] q[$]);
    busy_cnt = 32'h0;
    i2c_master_model_i.start();
    send({4'hA, cs, 1'b0}, 1'b1);
    send(a, 1'b1);
    foreach (q[i])
      send(q[i], 1'b1);
    i2c_master_model_i.stop();
  endtask

  // Polls right after Stop; a busy device must refuse the first try.
  task automatic poll(input logic exp_wait);
    logic a;
    int   n;
    n = 0;
    a = 1'b0;
    while (!a && n < 40)
    begin
      i2c_master_model_i.start();
      i2c_master_model_i.wr_byte({4'hA, cs, 1'b0}, a);
      i2c_master_model_i.stop();
      n++;
    end
    check("polls refused", {31'h0, exp_wait}, {31'h0, n > 1});
    check("ready ack", 32'h1, {31'h0, a});
    check("busy span", exp_wait ? WR_CYC : 0, busy_cnt);
  endtask

  task automatic read(input logic rnd, input logic [7:0] a, input logic [7:0] q[$]);
    logic [7:0] d;
    i2c_master_model_i.start();
    if (rnd)
    begin
      send({4'hA, cs, 1'b0}, 1'b1);
      send(a, 1'b1);
      i2c_master_model_i.start();
    end
    send({4'hA, cs, 1'b1}, 1'b1);
    foreach (q[i])
    begin
      i2c_master_model_i.rd_byte(i == q.size() - 1, d);
      check("read byte", {24'h0, q[i]}, {24'h0, d});
    end
    i2c_master_model_i.stop();
    check("line released", 32'h1, {31'h0, oe_n});
  endtask

  task automatic t_reset();
    check("oe_n", 32'h1, {31'h0, oe_n});
    check("out", 32'h0, {31'h0, out_bit});
    check("busy", 32'h0, {31'h0, busy});
  endtask

  task automatic t_bad_code();
    i2c_master_model_i.start();
    send(8'h50, 1'b0);
    i2c_master_model_i.stop();
    i2c_master_model_i.start();
    send(8'hB1, 1'b0);
    i2c_master_model_i.stop();
  endtask

  task automatic t_byte_write();
    set_in(1'b0, 3'h5);
    write_page(8'h10, '{8'h5A});
    poll(1'b1);
    set_in(1'b0, 3'h2);
    read(1'b1, 8'h10, '{8'h5A});
  endtask

  task automatic t_page_wrap();
    write_page(8'h1E, '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09});
    poll(1'b1);
    read(1'b0, 8'h00, '{8'h02});
    read(1'b1, 8'h18, '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
    read(1'b0, 8'h00, '{8'h08});
  endtask

  task automatic t_protect();
    set_in(1'b1, 3'h7);
    write_page(8'h10, '{8'hC3});
    poll(1'b0);
    read(1'b1, 8'h10, '{8'h5A});
    set_in(1'b0, 3'h0);
  endtask

  task automatic t_top_wrap();
    write_page(8'hFF, '{8'h77});
    poll(1'b1);
    write_page(8'h00, '{8'h11});
    poll(1'b1);
    read(1'b1, 8'hFF, '{8'h77, 8'h11});
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    wp = 1'b0;
    cs = 3'h0;
    busy_cnt = 32'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    t_reset();
    t_bad_code();
    t_byte_write();
    t_page_wrap();
    t_protect();
    t_top_wrap();
    end_of_test();
  end

  // The whole run needs well under half of this span.
  initial
  begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
